//--- hdl/usr_pkg.sv
// Purpose: shared constants and types of the serial status and rate select block
// Assumes: 32-bit apb, word-aligned registers, byte address = 4 * register index
// Notes:   all offsets, field positions, reset values and counts live here
package usr_pkg;

	// register indices and their byte addresses on the 12-bit apb address
	localparam logic [7:0]  IDX_STAT_SEL = 8'h91;
	localparam logic [7:0]  IDX_SBUF     = 8'h99;
	localparam logic [7:0]  IDX_INT_STAT = 8'ha0;
	localparam logic [7:0]  IDX_INT_MASK = 8'ha1;
	localparam logic [11:0] ADDR_STAT_SEL = {2'h0, IDX_STAT_SEL, 2'h0};
	localparam logic [11:0] ADDR_SBUF     = {2'h0, IDX_SBUF, 2'h0};
	localparam logic [11:0] ADDR_INT_STAT = {2'h0, IDX_INT_STAT, 2'h0};
	localparam logic [11:0] ADDR_INT_MASK = {2'h0, IDX_INT_MASK, 2'h0};

	// field positions in serial_status_clock_select
	localparam int POS_FE   = 7;
	localparam int POS_OVR  = 6;
	localparam int POS_COL  = 5;
	localparam int POS_HALF = 4;

	// interrupt status bits
	localparam int POS_INT_RX = 0;
	localparam int POS_INT_TX = 1;

	// reset values
	localparam logic [7:0] RST_STAT_SEL = 8'h00;
	localparam logic [7:0] RST_SBUF     = 8'h00;
	localparam logic [1:0] RST_INT      = 2'h0;

	// oversampling: baud ticks per bit and the mid-bit point of the start bit
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// status and clock selection fields
	typedef struct packed {
		logic       frame_error_flag;
		logic       receive_overrun_flag;
		logic       transmit_collision_flag;
		logic       baud_halving_control;
		logic [1:0] tx_rate_source_select;
		logic [1:0] rx_rate_source_select;
	} usr_ctrl_type;

	// serial engine phases, one-hot
	typedef enum logic [3:0] {
		PH_IDLE  = 4'b0001,
		PH_START = 4'b0010,
		PH_DATA  = 4'b0100,
		PH_STOP  = 4'b1000
	} usr_phase_type;

endpackage

//--- hdl/usr_rate_pick.sv
// Purpose: picks one of four timer ticks and applies the optional halving stage
// Assumes: timer ticks are one-cycle pulses synchronous to core_clk
// Notes:   output tick is registered, one cycle after the source tick
`timescale 1ns/1ps
`default_nettype none
module usr_rate_pick
	import usr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic [3:0] tick_src,
	input  wire logic [1:0] sel,
	input  wire logic       halve_off,
	output logic            tick_o
);

	logic sel_tick;
	logic phase_q;
	logic phase_d;
	logic tick_d;

	// halving passes every second selected tick; halve_off=1 passes all
	always_comb begin
		sel_tick = tick_src[sel];
		phase_d  = phase_q ^ sel_tick;
		tick_d   = sel_tick & (halve_off | phase_q);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 1'b0;
			tick_o  <= 1'b0;
		end else begin
			phase_q <= phase_d;
			tick_o  <= tick_d;
		end
	end

endmodule
`default_nettype wire

//--- hdl/usr_top.sv
// Purpose: serial port status flags, baud source selection and data buffer
// Assumes: apb slave with zero wait states; rx line synchronous to core_clk
// Notes:   16 baud ticks per bit; error flags never reach the interrupt line
// Function
// - Set overrun flag when a byte lands before the previous was read.
// - Error conditions only set flags and never raise an interrupt.
// - Bit 4 at zero halves the baud tick rate; one disables halving.
// - Bits 3-2 pick the transmit baud source among four timer ticks.
// - Bits 1-0 pick the receive baud source, independent of transmit.
// - Buffer address holds a write-only transmit and a read-only receive register.
// - Writing the buffer while idle loads the transmit register and starts sending.
// - Reading the buffer returns received data, not transmitted data.
`timescale 1ns/1ps
`default_nettype none
module usr_top
	import usr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  timer_tick,
	input  wire logic        rx_i,
	output logic             tx_o,
	output logic             irq_o
);

	usr_ctrl_type  ctrl_q, ctrl_d;
	logic [7:0]    tx_hold_q, tx_hold_d;
	logic [7:0]    rx_buf_q, rx_buf_d;
	logic          rx_full_q, rx_full_d;
	logic [1:0]    int_stat_q, int_stat_d;
	logic [1:0]    int_mask_q, int_mask_d;
	logic [31:0]   prdata_d;
	logic          irq_d;
	usr_phase_type tx_ph_q, tx_ph_d, rx_ph_q, rx_ph_d;
	logic [3:0]    tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic [2:0]    tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
	logic [7:0]    rx_shift_q, rx_shift_d;
	logic          tx_d;
	logic          tx_tick, rx_tick;
	logic          acc, wr, rd, hit_stat, hit_buf, hit_ist, hit_imask;
	logic          buf_wr, tx_busy, tx_done, rx_done, rx_bad_stop;

	// independent rate pickers for the two directions
	usr_rate_pick u_tx_rate (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.tick_src  (timer_tick),
		.sel       (ctrl_q.tx_rate_source_select),
		.halve_off (ctrl_q.baud_halving_control),
		.tick_o    (tx_tick)
	);

	usr_rate_pick u_rx_rate (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.tick_src  (timer_tick),
		.sel       (ctrl_q.rx_rate_source_select),
		.halve_off (ctrl_q.baud_halving_control),
		.tick_o    (rx_tick)
	);

	// apb decode; zero wait states, so every access completes in its first cycle
	always_comb begin
		hit_stat  = (paddr == ADDR_STAT_SEL);
		hit_buf   = (paddr == ADDR_SBUF);
		hit_ist   = (paddr == ADDR_INT_STAT);
		hit_imask = (paddr == ADDR_INT_MASK);
		acc       = psel & penable;
		wr        = acc & pwrite;
		rd        = acc & ~pwrite;
		buf_wr    = wr & hit_buf;
		pready    = 1'b1;
		pslverr   = acc & ~(hit_stat | hit_buf | hit_ist | hit_imask);
	end

	// read data is captured in the setup cycle so prdata comes from a flop
	always_comb begin
		prdata_d = prdata;
		if (psel && !penable && !pwrite) begin
			prdata_d = 32'h0000_0000;
			if (hit_stat)
				prdata_d[7:0] = ctrl_q;
			else if (hit_buf)
				prdata_d[7:0] = rx_buf_q;
			else if (hit_ist)
				prdata_d[1:0] = int_stat_q;
			else if (hit_imask)
				prdata_d[1:0] = int_mask_q;
		end
	end

	// register file; hardware sets win over software clears in the same cycle
	always_comb begin
		tx_busy    = (tx_ph_q != PH_IDLE);
		ctrl_d     = ctrl_q;
		int_mask_d = int_mask_q;
		int_stat_d = int_stat_q;
		rx_full_d  = rx_full_q;
		rx_buf_d   = rx_buf_q;
		tx_hold_d  = tx_hold_q;
		if (wr && hit_stat) begin
			// writing zero clears an error flag, writing one leaves it alone
			ctrl_d.frame_error_flag        = ctrl_q.frame_error_flag & pwdata[POS_FE];
			ctrl_d.receive_overrun_flag    = ctrl_q.receive_overrun_flag & pwdata[POS_OVR];
			ctrl_d.transmit_collision_flag = ctrl_q.transmit_collision_flag & pwdata[POS_COL];
			ctrl_d.baud_halving_control    = pwdata[POS_HALF];
			ctrl_d.tx_rate_source_select   = pwdata[3:2];
			ctrl_d.rx_rate_source_select   = pwdata[1:0];
		end
		if (wr && hit_imask)
			int_mask_d = pwdata[1:0];
		// clear only what the read returned, so an event at the setup edge survives
		if (rd && hit_ist)
			int_stat_d = int_stat_q & ~prdata[1:0];
		if (rd && hit_buf)
			rx_full_d = 1'b0;
		// a write during a frame is dropped so the byte on the wire stays intact
		if (buf_wr && !tx_busy)
			tx_hold_d = pwdata[7:0];
		if (buf_wr && tx_busy)
			ctrl_d.transmit_collision_flag = 1'b1;
		if (rx_done) begin
			rx_buf_d  = rx_shift_q;
			rx_full_d = 1'b1;
			int_stat_d[POS_INT_RX] = 1'b1;
			if (rx_full_q && !(rd && hit_buf))
				ctrl_d.receive_overrun_flag = 1'b1;
			if (rx_bad_stop)
				ctrl_d.frame_error_flag = 1'b1;
		end
		if (tx_done)
			int_stat_d[POS_INT_TX] = 1'b1;
		// only receive and transmit completion feed the interrupt line
		irq_d = |(int_stat_q & int_mask_q);
	end

	// transmit engine: start, eight data bits lsb first, one stop bit
	always_comb begin
		tx_ph_d  = tx_ph_q;
		tx_cnt_d = tx_cnt_q;
		tx_bit_d = tx_bit_q;
		tx_d     = tx_o;
		tx_done  = 1'b0;
		unique case (tx_ph_q)
			PH_IDLE: begin
				tx_d = 1'b1;
				if (buf_wr) begin
					tx_ph_d  = PH_START;
					tx_cnt_d = 4'h0;
					tx_bit_d = 3'h0;
				end
			end
			PH_START: begin
				tx_d = 1'b0;
				if (tx_tick) begin
					tx_cnt_d = tx_cnt_q + 4'h1;
					if (tx_cnt_q == OVS_LAST)
						tx_ph_d = PH_DATA;
				end
			end
			PH_DATA: begin
				tx_d = tx_hold_q[tx_bit_q];
				if (tx_tick) begin
					tx_cnt_d = tx_cnt_q + 4'h1;
					if (tx_cnt_q == OVS_LAST) begin
						tx_bit_d = tx_bit_q + 3'h1;
						if (tx_bit_q == BIT_LAST)
							tx_ph_d = PH_STOP;
					end
				end
			end
			PH_STOP: begin
				tx_d = 1'b1;
				if (tx_tick) begin
					tx_cnt_d = tx_cnt_q + 4'h1;
					if (tx_cnt_q == OVS_LAST) begin
						tx_ph_d = PH_IDLE;
						tx_done = 1'b1;
					end
				end
			end
			default: tx_ph_d = PH_IDLE;
		endcase
	end

	// receive engine: start bit checked at its middle, data and stop bits sampled at their middles
	always_comb begin
		rx_ph_d     = rx_ph_q;
		rx_cnt_d    = rx_cnt_q;
		rx_bit_d    = rx_bit_q;
		rx_shift_d  = rx_shift_q;
		rx_done     = 1'b0;
		rx_bad_stop = 1'b0;
		unique case (rx_ph_q)
			PH_IDLE: begin
				if (rx_tick && !rx_i) begin
					rx_ph_d  = PH_START;
					rx_cnt_d = 4'h0;
				end
			end
			PH_START: begin
				if (rx_tick) begin
					rx_cnt_d = rx_cnt_q + 4'h1;
					if (rx_cnt_q == OVS_MID) begin
						rx_ph_d  = rx_i ? PH_IDLE : PH_DATA;
						rx_cnt_d = 4'h0;
						rx_bit_d = 3'h0;
					end
				end
			end
			PH_DATA: begin
				if (rx_tick) begin
					rx_cnt_d = rx_cnt_q + 4'h1;
					if (rx_cnt_q == OVS_LAST) begin
						rx_shift_d = {rx_i, rx_shift_q[7:1]};
						rx_bit_d   = rx_bit_q + 3'h1;
						if (rx_bit_q == BIT_LAST)
							rx_ph_d = PH_STOP;
					end
				end
			end
			PH_STOP: begin
				if (rx_tick) begin
					rx_cnt_d = rx_cnt_q + 4'h1;
					if (rx_cnt_q == OVS_LAST) begin
						rx_ph_d     = PH_IDLE;
						rx_done     = 1'b1;
						rx_bad_stop = ~rx_i;
					end
				end
			end
			default: rx_ph_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q     <= RST_STAT_SEL;
			tx_hold_q  <= RST_SBUF;
			rx_buf_q   <= RST_SBUF;
			rx_full_q  <= 1'b0;
			int_stat_q <= RST_INT;
			int_mask_q <= RST_INT;
			prdata     <= 32'h0000_0000;
			irq_o      <= 1'b0;
			tx_ph_q    <= PH_IDLE;
			tx_cnt_q   <= 4'h0;
			tx_bit_q   <= 3'h0;
			tx_o       <= 1'b1;
			rx_ph_q    <= PH_IDLE;
			rx_cnt_q   <= 4'h0;
			rx_bit_q   <= 3'h0;
			rx_shift_q <= 8'h00;
		end else begin
			ctrl_q     <= ctrl_d;
			tx_hold_q  <= tx_hold_d;
			rx_buf_q   <= rx_buf_d;
			rx_full_q  <= rx_full_d;
			int_stat_q <= int_stat_d;
			int_mask_q <= int_mask_d;
			prdata     <= prdata_d;
			irq_o      <= irq_d;
			tx_ph_q    <= tx_ph_d;
			tx_cnt_q   <= tx_cnt_d;
			tx_bit_q   <= tx_bit_d;
			tx_o       <= tx_d;
			rx_ph_q    <= rx_ph_d;
			rx_cnt_q   <= rx_cnt_d;
			rx_bit_q   <= rx_bit_d;
			rx_shift_q <= rx_shift_d;
		end
	end

	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_fe_set: assert property (rx_done && rx_bad_stop |=> ctrl_q.frame_error_flag)
		else $error("frame error not flagged");
	chk_ovr_set: assert property (rx_done && rx_full_q && !(rd && hit_buf)
		|=> ctrl_q.receive_overrun_flag)
		else $error("overrun not flagged");
	chk_col_set: assert property (buf_wr && tx_busy |=> ctrl_q.transmit_collision_flag)
		else $error("collision not flagged");
	chk_irq_cause: assert property (irq_o |-> $past(|(int_stat_q & int_mask_q)))
		else $error("interrupt without enabled completion event");
	chk_half_gap: assert property (!ctrl_q.baud_halving_control && tx_tick
		&& $stable(ctrl_q) |=> !tx_tick)
		else $error("halved tick fired twice in a row");
	chk_tx_source: assert property (ctrl_q.baud_halving_control && $stable(ctrl_q)
		|-> tx_tick == $past(timer_tick[ctrl_q.tx_rate_source_select]))
		else $error("transmit tick not from selected source");
	chk_rx_source: assert property (ctrl_q.baud_halving_control && $stable(ctrl_q)
		|-> rx_tick == $past(timer_tick[ctrl_q.rx_rate_source_select]))
		else $error("receive tick not from selected source");
	chk_buf_read: assert property (rd && hit_buf && $past(psel && !penable)
		|-> prdata[7:0] == $past(rx_buf_q))
		else $error("buffer read not from receive register");
	chk_tx_start: assert property (buf_wr && !tx_busy
		|=> tx_ph_q == PH_START && tx_hold_q == $past(pwdata[7:0]) ##1 !tx_o)
		else $error("buffer write did not start transmission");
	chk_flag_hold: assert property (ctrl_q.frame_error_flag && !(wr && hit_stat)
		|=> ctrl_q.frame_error_flag)
		else $error("frame error flag cleared without write");

	cov_frame_err: cover property (rx_done && rx_bad_stop);
	cov_overrun: cover property (rx_done && rx_full_q);
	cov_collision: cover property (buf_wr && tx_busy);
	cov_irq: cover property ($rose(irq_o));

endmodule
`default_nettype wire

//--- verification/usr_far_end.sv
// Purpose: remote serial device on the transmit and receive lines
// Assumes: one bit lasts bit_cycles core_clk cycles, set by the bench
// Notes:   behavioural; the line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module usr_far_end (
	input  wire logic core_clk,
	input  wire logic tx_i,
	output logic      rx_o
);
	int         bit_cycles = 16;
	int         nrx        = 0;
	logic [7:0] last_byte  = 8'h00;
	logic [7:0] rx_bits;

	initial rx_o = 1'b1;

	// receiver samples mid-bit, so a one-cycle tick lag in the block does not matter
	always begin
		@(negedge tx_i);
		repeat (bit_cycles / 2) @(posedge core_clk);
		if (tx_i === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cycles) @(posedge core_clk);
				rx_bits[i] = tx_i;
			end
			repeat (bit_cycles) @(posedge core_clk);
			last_byte = rx_bits;
			nrx++;
		end
	end

	// one frame, lsb first; a low stop level provokes a frame error
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		@(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			rx_o <= f[i];
			repeat (bit_cycles) @(posedge core_clk);
		end
		rx_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- verification/test_usr_top.sv
// Purpose: self-checking bench of the serial status and rate select block
// Assumes: timer ticks every cycle, so a bit lasts 16 cycles, 32 when halved
// Notes:   the bench still polls pready although the block answers at once
`timescale 1ns/1ps
`default_nettype none
module test_usr_top import usr_pkg::*;;
	logic        core_clk   = 1'b0;
	logic        nrst       = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [11:0] paddr      = 12'h000;
	logic [31:0] pwdata     = 32'h0;
	logic [3:0]  timer_tick = 4'h0;
	logic [3:0]  tick_en    = 4'h1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_i;
	logic        tx_o;
	logic        irq_o;
	logic [31:0] rd;
	logic        rd_err;
	int          errors      = 0;
	int          check_count = 0;

	always #2 core_clk = ~core_clk;
	// only enabled sources tick, so a wrong source pick stalls the link
	always @(posedge core_clk) timer_tick <= tick_en;

	usr_top u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_tick(timer_tick), .rx_i(rx_i),
		.tx_o(tx_o), .irq_o(irq_o));
	usr_far_end u_far (.core_clk(core_clk), .tx_i(tx_o), .rx_o(rx_i));

	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang();
		errors++;
		$display("BAD timeout expected 1 seen 0");
		complete_run();
	endtask

	// one transfer; the request holds until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) hang();
		rd = prdata;
		rd_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_frames(input int n);
		int c;
		c = 0;
		while (u_far.nrx != n && c < 3000) begin
			@(posedge core_clk);
			c++;
		end
		if (c >= 3000) hang();
		// the far end counts a frame mid stop bit; let the stop bit run out
		// so the next buffer write finds the transmitter idle, not colliding
		repeat (u_far.bit_cycles) @(posedge core_clk);
	endtask

	task automatic wait_irq();
		int c;
		c = 0;
		while (irq_o !== 1'b1 && c < 3000) begin
			@(posedge core_clk);
			c++;
		end
		if (c >= 3000) hang();
	endtask

	// reset values, then an unmapped address is refused
	task automatic t_reset();
		apb(1'b0, ADDR_STAT_SEL, 32'h0);
		chk("stat_reset", rd, {24'h0, RST_STAT_SEL});
		apb(1'b0, ADDR_SBUF, 32'h0);
		chk("rx_reset", rd, {24'h0, RST_SBUF});
		apb(1'b1, 12'h000, 32'hff);
		chk("unmapped_err", rd_err, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped_rd", rd, 32'h0);
	endtask

	// 24 cycles after the start edge: still in start bit only when halved
	task automatic t_half(input logic h);
		int n0;
		int c;
		n0 = u_far.nrx;
		u_far.bit_cycles = h ? 16 : 32;
		apb(1'b1, ADDR_STAT_SEL, {27'h0, h, 4'h0});
		apb(1'b1, ADDR_SBUF, 32'hff);
		c = 0;
		while (tx_o !== 1'b0 && c < 100) begin
			@(posedge core_clk);
			c++;
		end
		if (c >= 100) hang();
		repeat (24) @(posedge core_clk);
		chk("bit_time", tx_o, h);
		wait_frames(n0 + 1);
		chk("tx_ff", u_far.last_byte, 8'hff);
	endtask

	// both directions on source k, with interrupt raise, mask and clear
	task automatic t_route(input logic [1:0] k);
		tick_en <= 4'h1 << k;
		u_far.bit_cycles = 16;
		apb(1'b1, ADDR_STAT_SEL, {27'h0, 1'b1, k, k});
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		apb(1'b1, ADDR_INT_MASK, 32'h2);
		apb(1'b1, ADDR_SBUF, {24'h0, 8'h3c ^ k});
		wait_irq();
		chk("tx_byte", u_far.last_byte, 8'h3c ^ k);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chk("int_tx", rd, 32'h2);
		apb(1'b1, ADDR_INT_MASK, 32'h1);
		chk("irq_clear", irq_o, 32'h0);
		u_far.send(8'hc3 ^ k, 1'b1);
		wait_irq();
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chk("int_rx", rd, 32'h1);
		apb(1'b0, ADDR_SBUF, 32'h0);
		chk("rx_byte", rd, {24'h0, 8'hc3 ^ k});
	endtask

	// error flags: set, sticky, cleared by zero, never on the interrupt line
	task automatic t_errors();
		int n0;
		tick_en <= 4'h1;
		apb(1'b1, ADDR_STAT_SEL, 32'h10);
		apb(1'b1, ADDR_INT_MASK, 32'h2);
		u_far.send(8'h81, 1'b0);
		apb(1'b0, ADDR_STAT_SEL, 32'h0);
		chk("frame_err", rd, 32'h90);
		u_far.send(8'h42, 1'b1);
		apb(1'b1, ADDR_STAT_SEL, 32'hd0);
		apb(1'b0, ADDR_STAT_SEL, 32'h0);
		chk("overrun", rd, 32'hd0);
		chk("irq_err", irq_o, 32'h0);
		apb(1'b0, ADDR_SBUF, 32'h0);
		chk("rx_last", rd, 32'h42);
		apb(1'b1, ADDR_STAT_SEL, 32'h10);
		apb(1'b0, ADDR_STAT_SEL, 32'h0);
		chk("flags_clr", rd, 32'h10);
		n0 = u_far.nrx;
		apb(1'b1, ADDR_SBUF, 32'h11);
		apb(1'b1, ADDR_SBUF, 32'h22);
		apb(1'b0, ADDR_STAT_SEL, 32'h0);
		chk("collision", rd, 32'h30);
		chk("irq_col", irq_o, 32'h0);
		apb(1'b0, ADDR_SBUF, 32'h0);
		chk("rx_not_tx", rd, 32'h42);
		wait_irq();
		repeat (200) @(posedge core_clk);
		chk("tx_count", u_far.nrx, n0 + 1);
		chk("tx_first", u_far.last_byte, 8'h11);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_half(1'b0);
		t_half(1'b1);
		for (int k = 0; k < 4; k++) t_route(k[1:0]);
		t_errors();
		complete_run();
	end
endmodule
`default_nettype wire
